// File: inc/stream_regs_pkg.sv
// Package: register map, field layout and reset values of the stream pattern register bank
package stream_regs_pkg;
	// Offsets are word indices on the bus: byte address = 4 * index
	localparam logic [7:0] IDX_PATTERN_TWO_LOW = 8'h1B;
	localparam logic [7:0] IDX_PATTERN_TWO_HIGH = 8'h1C;
	localparam logic [7:0] IDX_STREAM_CONTROL = 8'h21;
	localparam logic [7:0] IDX_CHANNEL_LOCAL = 8'h22;
	// Channel select index is a local choice, clear of the other registers
	localparam logic [7:0] IDX_CHANNEL_SELECT = 8'h05;

	localparam int ADDR_W = 10;

	localparam logic [7:0] RST_PATTERN_LOW = 8'h00;
	localparam logic [7:0] RST_PATTERN_HIGH = 8'h00;
	localparam logic [7:0] RST_STREAM_CONTROL = 8'h00;
	localparam logic [7:0] RST_CHANNEL_LOCAL = 8'h00;

	// Stream control fields
	localparam int POS_LSB_FIRST = 7;
	localparam int POS_LOW_RATE = 3;
	localparam int POS_RES_LO = 0;
	localparam int RES_W = 3;
	// Channel local control fields
	localparam int POS_CH_OUT_RESET = 1;
	localparam int POS_CH_POWER_DOWN = 0;

	typedef enum logic [2:0] {
		RES_NATIVE = 3'h0,
		RES_BITS_8 = 3'h1,
		RES_BITS_10 = 3'h2,
		RES_BITS_12 = 3'h3,
		RES_BITS_14 = 3'h4
	} resolution_t;

	typedef struct packed {
		logic lsb_first;
		logic low_encode_rate;
		resolution_t resolution;
		logic [4:0] word_bits;
	} stream_cfg_t;
endpackage : stream_regs_pkg

// File: rtl/stream_pattern_regs.sv
// Module: configuration register bank for test pattern two, stream and channel controls
// Behaviour
// - Pattern two low byte register, resets zero
// - Pattern two high byte, next register
// - Bit-order bit selects LSB first, global
// - Low encode rate mode bit, default off
// - Resolution code selects 8/10/12/14 or native
// - Output reset holds selected channels' path
// - Power-down bit powers off selected channels
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/1ps
module stream_pattern_regs
	import stream_regs_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int NATIVE_BITS = 12
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic err_o,
	output logic [15:0] user_pattern_two_o,
	output stream_cfg_t stream_cfg_o,
	output logic [CHANNELS-1:0] channel_out_reset_o,
	output logic [CHANNELS-1:0] channel_power_down_o
);

	initial begin
		if (CHANNELS < 1 || CHANNELS > 8)
			$error("CHANNELS must be 1 to 8");
		if (NATIVE_BITS < 1 || NATIVE_BITS > 16)
			$error("NATIVE_BITS must be 1 to 16");
	end

	// Word length for a resolution code; unused codes fall back to native
	function automatic logic [4:0] word_len(input logic [2:0] code);
		unique case (code)
			RES_BITS_8: word_len = 5'h08;
			RES_BITS_10: word_len = 5'h0A;
			RES_BITS_12: word_len = 5'h0C;
			RES_BITS_14: word_len = 5'h0E;
			default: word_len = 5'(NATIVE_BITS);
		endcase
	endfunction

	logic [7:0] pat_low_q, pat_high_q, stream_ctl_q, ch_local_q, ch_select_q;
	logic ack_q, err_q;
	logic [31:0] rdata_q;

	wire logic [7:0] index = adr_i[ADDR_W-1:2];
	wire logic req = cyc_i && stb_i && !ack_q && !err_q;
	wire logic hit_low = index == IDX_PATTERN_TWO_LOW;
	wire logic hit_high = index == IDX_PATTERN_TWO_HIGH;
	wire logic hit_ctl = index == IDX_STREAM_CONTROL;
	wire logic hit_local = index == IDX_CHANNEL_LOCAL;
	wire logic hit_sel = index == IDX_CHANNEL_SELECT;
	wire logic mapped = hit_low || hit_high || hit_ctl || hit_local || hit_sel;
	wire logic wr_lane = req && we_i && sel_i[0] && mapped;
	wire logic [7:0] rd_byte = hit_low ? pat_low_q :
		hit_high ? pat_high_q :
		hit_ctl ? stream_ctl_q :
		hit_local ? ch_local_q :
		hit_sel ? ch_select_q : 8'h00;
	// Bits marked don't-care in control registers are not stored
	wire logic [7:0] ctl_mask = 8'h8F;
	wire logic [7:0] local_mask = 8'h03;
	wire logic [7:0] chan_mask = 8'((9'h001 << CHANNELS) - 9'h001);
	wire logic [CHANNELS-1:0] chan_sel = ch_select_q[CHANNELS-1:0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pat_low_q <= RST_PATTERN_LOW;
			pat_high_q <= RST_PATTERN_HIGH;
			stream_ctl_q <= RST_STREAM_CONTROL;
			ch_local_q <= RST_CHANNEL_LOCAL;
			ch_select_q <= chan_mask;
		end else if (wr_lane) begin
			if (hit_low) pat_low_q <= dat_i[7:0];
			if (hit_high) pat_high_q <= dat_i[7:0];
			if (hit_ctl) stream_ctl_q <= dat_i[7:0] & ctl_mask;
			if (hit_local) ch_local_q <= dat_i[7:0] & local_mask;
			if (hit_sel) ch_select_q <= dat_i[7:0] & chan_mask;
		end
	end

	// Answer one cycle after the strobe; unmapped index gets err
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req && mapped;
			err_q <= req && !mapped;
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	// Outputs are re-registered so every output comes from a flop
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			user_pattern_two_o <= 16'h0000;
			stream_cfg_o <= '{1'b0, 1'b0, RES_NATIVE, 5'(NATIVE_BITS)};
			channel_out_reset_o <= '0;
			channel_power_down_o <= '0;
		end else begin
			user_pattern_two_o <= {pat_high_q, pat_low_q};
			stream_cfg_o.lsb_first <= stream_ctl_q[POS_LSB_FIRST];
			stream_cfg_o.low_encode_rate <= stream_ctl_q[POS_LOW_RATE];
			stream_cfg_o.resolution <= resolution_t'(stream_ctl_q[POS_RES_LO +: RES_W]);
			stream_cfg_o.word_bits <= word_len(stream_ctl_q[POS_RES_LO +: RES_W]);
			channel_out_reset_o <= chan_sel & {CHANNELS{ch_local_q[POS_CH_OUT_RESET]}};
			channel_power_down_o <= chan_sel & {CHANNELS{ch_local_q[POS_CH_POWER_DOWN]}};
		end
	end

	assign dat_o = rdata_q;
	assign ack_o = ack_q;
	assign err_o = err_q;

	wire logic wr_ctl = wr_lane && hit_ctl;
	wire logic wr_local = wr_lane && hit_local;

	a_pattern_low_out: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_lane && hit_low |-> ##2 user_pattern_two_o[7:0] == $past(dat_i[7:0], 2))
		else $error("pattern low byte not on output");

	a_pattern_high_out: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_lane && hit_high |-> ##2 user_pattern_two_o[15:8] == $past(dat_i[7:0], 2))
		else $error("pattern high byte not on output");

	a_bit_order_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl |-> ##2 stream_cfg_o.lsb_first == $past(dat_i[7], 2))
		else $error("bit order not applied");

	a_low_rate_follow: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl |-> ##2 stream_cfg_o.low_encode_rate == $past(dat_i[3], 2))
		else $error("low encode rate not applied");

	a_res_ten_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl && dat_i[2:0] == 3'h2 |-> ##2 stream_cfg_o.word_bits == 5'h0A)
		else $error("resolution 010 not 10 bits");

	a_res_fourteen: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl && dat_i[2:0] == 3'h4 |-> ##2 stream_cfg_o.word_bits == 5'h0E)
		else $error("resolution 100 not 14 bits");

	a_res_eight_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl && dat_i[2:0] == 3'h1 |-> ##2 stream_cfg_o.word_bits == 5'h08)
		else $error("resolution 001 not 8 bits");

	a_res_twelve_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl && dat_i[2:0] == 3'h3 |-> ##2 stream_cfg_o.word_bits == 5'h0C)
		else $error("resolution 011 not 12 bits");

	a_res_native: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl && dat_i[2:0] == 3'h0 |-> ##2 stream_cfg_o.word_bits == 5'(NATIVE_BITS))
		else $error("resolution 000 not native");

	a_res_spare_native: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl && dat_i[2:0] > 3'h4 |-> ##2 stream_cfg_o.word_bits == 5'(NATIVE_BITS))
		else $error("spare resolution code not native");

	a_res_code_out: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_ctl |-> ##2 stream_cfg_o.resolution == $past(dat_i[2:0], 2))
		else $error("resolution code not on output");

	a_out_reset_local: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_local |-> ##2 channel_out_reset_o == ($past(chan_sel, 2)
			& {CHANNELS{$past(dat_i[1], 2)}}))
		else $error("output reset not local");

	a_power_down_local: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_local |-> ##2 channel_power_down_o == ($past(chan_sel, 2)
			& {CHANNELS{$past(dat_i[0], 2)}}))
		else $error("power down not local");

	a_out_reset_unsel: assert property (@(posedge clk_i) disable iff (rst_i)
		(channel_out_reset_o & ~$past(chan_sel)) == '0)
		else $error("output reset on unselected channel");

	a_power_down_unsel: assert property (@(posedge clk_i) disable iff (rst_i)
		(channel_power_down_o & ~$past(chan_sel)) == '0)
		else $error("power down on unselected channel");

	a_pattern_reset: assert property (@(posedge clk_i)
		rst_i |=> user_pattern_two_o == 16'h0000)
		else $error("pattern not zero after reset");

	a_stream_reset: assert property (@(posedge clk_i)
		rst_i |=> !stream_cfg_o.lsb_first && !stream_cfg_o.low_encode_rate
			&& stream_cfg_o.word_bits == 5'(NATIVE_BITS))
		else $error("stream control not default after reset");

	a_channel_reset: assert property (@(posedge clk_i)
		rst_i |=> channel_out_reset_o == '0 && channel_power_down_o == '0)
		else $error("channel controls not off after reset");

	a_pattern_stable: assert property (@(posedge clk_i) disable iff (rst_i)
		!wr_lane |=> $stable(pat_low_q) && $stable(pat_high_q))
		else $error("pattern changed without a write");

	// Unmapped write stores nothing
	a_unmapped_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
		req && we_i && !mapped |=> $stable(stream_ctl_q) && $stable(ch_local_q)
			&& $stable(pat_low_q) && $stable(pat_high_q))
		else $error("unmapped write changed a register");

	// Disabled low lane stores nothing
	a_lane_gate: assert property (@(posedge clk_i) disable iff (rst_i)
		req && we_i && !sel_i[0] |=> $stable(stream_ctl_q) && $stable(ch_local_q)
			&& $stable(pat_low_q) && $stable(pat_high_q))
		else $error("write without low lane stored");

	// Reserved control bits stay clear
	a_ctl_spare_clear: assert property (@(posedge clk_i) disable iff (rst_i)
		stream_ctl_q[6:4] == 3'h0 && ch_local_q[7:2] == 6'h00)
		else $error("reserved control bits stored");

	// Select covers existing channels
	a_select_range: assert property (@(posedge clk_i) disable iff (rst_i)
		(ch_select_q & ~chan_mask) == 8'h00)
		else $error("channel select beyond channel count");

	a_read_low: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && hit_low |=> dat_o[7:0] == $past(pat_low_q))
		else $error("pattern low byte read wrong");

	a_read_high: assert property (@(posedge clk_i) disable iff (rst_i)
		req && !we_i && hit_high |=> dat_o[7:0] == $past(pat_high_q))
		else $error("pattern high byte read wrong");

	// Upper read bits are zero
	a_read_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o |-> dat_o[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");

	// Each request answered once
	a_bus_answer: assert property (@(posedge clk_i) disable iff (rst_i)
		req |=> (ack_o ^ err_o))
		else $error("bus request not answered in one cycle");

	// No answer without request
	a_bus_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		!req |=> !ack_o && !err_o)
		else $error("answer without a request");

	// Answers last one cycle
	a_answer_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
		ack_o || err_o |=> !ack_o && !err_o)
		else $error("answer longer than one cycle");

	c_write_pattern: cover property (@(posedge clk_i) disable iff (rst_i) wr_lane && hit_high);
	c_lsb_first: cover property (@(posedge clk_i) disable iff (rst_i) stream_cfg_o.lsb_first);
	c_power_down: cover property (@(posedge clk_i) disable iff (rst_i) |channel_power_down_o);
	c_unmapped: cover property (@(posedge clk_i) disable iff (rst_i) err_o);
	c_res_fourteen: cover property (@(posedge clk_i) disable iff (rst_i)
		stream_cfg_o.word_bits == 5'h0E);

endmodule // stream_pattern_regs

// File: dv/wb_host.sv
// Host model: Wishbone classic master issuing single register cycles
`timescale 1ns/1ps
module wb_host (
	input wire logic clk_i,
	input wire logic ack_i,
	input wire logic err_i,
	input wire logic [31:0] dat_i,
	output logic cyc_o = 1'b0,
	output logic stb_o = 1'b0,
	output logic we_o = 1'b0,
	output logic [9:0] adr_o = 10'h000,
	output logic [3:0] sel_o = 4'h0,
	output logic [31:0] dat_o = 32'h0
);
	// Code r: 0 ack, 1 err, 2 no answer within the bound
	task automatic xfer(input logic w, input logic [9:0] a, input logic [7:0] d,
		output logic [31:0] q, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc_o, stb_o, we_o, sel_o} <= {2'h3, w, 4'hF};
		adr_o <= a;
		dat_o <= {24'h0, d};
		// Look mid-cycle so the answer is seen before the edge that samples it
		do begin
			@(negedge clk_i);
			n++;
		end while (ack_i !== 1'b1 && err_i !== 1'b1 && n < 16);
		q = dat_i;
		r = (ack_i === 1'b1) ? 2'h0 : (err_i === 1'b1) ? 2'h1 : 2'h2;
		// Request stands through the edge at which the answer is sampled
		@(posedge clk_i);
		{cyc_o, stb_o} <= 2'h0;
		// Released address and data lines must not keep showing the old value
		adr_o <= ~adr_o;
		dat_o <= ~dat_o;
	endtask
endmodule // wb_host

// File: dv/tb_stream_pattern_regs.sv
// Testbench: register access and control outputs of the stream pattern bank
`timescale 1ns/1ps
module tb_stream_pattern_regs;
	import stream_regs_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc, stb, we, ack, err;
	logic [9:0] adr;
	logic [3:0] sel, ch_rst, ch_pd;
	logic [31:0] wd, rdat;
	logic [15:0] pat;
	stream_cfg_t cfg;
	int error_cnt = 0;
	int n_checks = 0;
	wb_host host (.clk_i(clk_i), .ack_i(ack), .err_i(err), .dat_i(rdat), .cyc_o(cyc),
		.stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wd));
	stream_pattern_regs dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd), .dat_o(rdat), .ack_o(ack),
		.err_o(err), .user_pattern_two_o(pat), .stream_cfg_o(cfg),
		.channel_out_reset_o(ch_rst), .channel_power_down_o(ch_pd));
	initial forever #25 clk_i = ~clk_i;
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	// Two edges after the answer the control outputs have settled
	task automatic xf(input logic w, input logic [9:0] a, input logic [7:0] d,
		input logic [1:0] er, input logic [31:0] ex);
		logic [31:0] q;
		logic [1:0] r;
		host.xfer(w, a, d, q, r);
		if (r == 2'h2) begin
			error_cnt++;
			results();
		end
		chk("response", {30'h0, er}, {30'h0, r});
		if (!w) chk("read data", ex, q);
		repeat (2) @(posedge clk_i);
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		xf(1'b1, a, d, 2'h0, 32'h0);
	endtask
	task automatic rd(input logic [9:0] a, input logic [31:0] ex);
		xf(1'b0, a, 8'h00, 2'h0, ex);
	endtask
	initial begin
		logic [7:0] v;
		logic [4:0] wb;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		chk("pattern", 32'h0, {16'h0, pat});
		chk("stream cfg", 32'h00C, {22'h0, cfg});
		chk("channel ctl", 32'h0, {24'h0, ch_rst, ch_pd});
		rd(10'h06C, 32'h0);
		rd(10'h070, 32'h0);
		rd(10'h084, 32'h0);
		rd(10'h088, 32'h0);
		$display("test reset done");
		wr(10'h06C, 8'hA5);
		wr(10'h070, 8'h3C);
		chk("pattern", 32'h3CA5, {16'h0, pat});
		rd(10'h06C, 32'hA5);
		rd(10'h071, 32'h3C);
		$display("test pattern done");
		// Every resolution code, reserved bits set on the write
		for (int c = 0; c < 8; c++) begin
			v = {c[0], 3'h7, c[1], c[2:0]};
			wb = (c == 0 || c > 4) ? 5'h0C : 5'(6 + 2 * c);
			wr(10'h084, v);
			chk("stream cfg", {22'h0, c[0], c[1], 3'(c), wb}, {22'h0, cfg});
			rd(10'h084, {24'h0, v & 8'h8F});
		end
		$display("test stream done");
		wr(10'h014, 8'h05);
		wr(10'h088, 8'hFF);
		chk("channel ctl", 32'h55, {24'h0, ch_rst, ch_pd});
		rd(10'h088, 32'h03);
		wr(10'h088, 8'h01);
		chk("channel ctl", 32'h05, {24'h0, ch_rst, ch_pd});
		$display("test channel done");
		xf(1'b0, 10'h3FC, 8'h00, 2'h1, 32'h0);
		xf(1'b1, 10'h3FC, 8'hFF, 2'h1, 32'h0);
		chk("pattern", 32'h3CA5, {16'h0, pat});
		$display("test unmapped done");
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk("pattern", 32'h0, {16'h0, pat});
		chk("stream cfg", 32'h00C, {22'h0, cfg});
		$display("test second reset done");
		results();
	end
endmodule // tb_stream_pattern_regs
